// ---- shared/thermal_overload_pin_timer_pkg.sv ----
// constants and carrier types for the overload timer and fan_speed_pulse_input pulse config block
package thermal_overload_pin_timer_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] INT_STATUS2_ADDR     = 8'h42;
  localparam logic [7:0] DURATION_STATUS_ADDR = 8'h79;
  localparam logic [7:0] DURATION_LIMIT_ADDR  = 8'h7A;
  localparam logic [7:0] PULSES_PER_REV_ADDR  = 8'h7B;

  // field positions
  localparam int unsigned EXCEEDED_BIT = 5;
  localparam int unsigned FIRST_FAN_LSB  = 0;
  localparam int unsigned SECOND_FAN_LSB = 2;
  localparam int unsigned THIRD_FAN_LSB  = 4;
  localparam int unsigned FOURTH_FAN_LSB = 6;

  // values after reset
  localparam logic [7:0] DURATION_LIMIT_RST = 8'h00;
  localparam logic [7:0] PULSES_PER_REV_RST = 8'h55;

  ////////////////////////////////////////////////////////////////////////////////
  // timing: one count is 22.76 ms
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned DURATION_UNIT_NS = 22_760_000;
  localparam int unsigned TICK_CYCLES    = DURATION_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned PRESCALE_W     = 22;
  // reading above one bit needs two units, 45.52 ms
  localparam logic [7:0] FIRST_THRESHOLD = 8'h02;
  localparam logic [7:0] COUNT_MAX       = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    TIMER_IDLE   = 2'b01,
    TIMER_TIMING = 2'b10
  } timer_state_e;

  typedef struct packed {
    logic [2:0] fourth;
    logic [2:0] third;
    logic [2:0] second;
    logic [2:0] first;
  } fan_pulses_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage : thermal_overload_pin_timer_pkg

// ---- logic/thermal_overload_pin_duration_limit.sv ----
// overload duration timer, limit compare and fan_pulses_per_rev registers

////////////////////////////////////////////////////////////////////////////////
// Function
// - limit is eight bits, each count worth 22.76 ms of assertion
// - programmable limit spans 45.52 ms to 5.80 s across codes 1 to 254
// - time beyond limit sets bit 5 of interrupt status 2 at 0x42
// - limit zero flags exceedance immediately on overload assertion
// - limit register 0x7A is read/write, resets to zero
// - fan one pulse count in bits 1:0, code plus one pulses
// - fans two to four use bits 3:2, 5:4, 7:6 alike
// - pulses-per-rev register 0x7B is read/write, resets to 0x55
// - upper seven duration bits read zero until beyond 45.52 ms
// - lowest status bit set on assertion, cleared on read, then count lsb ORed with it
module thermal_overload_pin_duration_limit #(
  parameter int unsigned TICK_CYCLES = thermal_overload_pin_timer_pkg::TICK_CYCLES
) (
  // clock, reset, enable
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          clk_en_in,
  // register port
  input  wire thermal_overload_pin_timer_pkg::reg_req_s     reg_req_in,
  output logic [7:0]                         reg_rdata_out,
  // overload pin, active low
  input  wire logic                          thermal_overload_pin_n_in,
  // status and configuration out
  output logic                               duration_exceeded_flag_out,
  output thermal_overload_pin_timer_pkg::fan_pulses_s       fan_pulses_out
);

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    thermal_overload_pin_timer_pkg::timer_state_e                     state;
    logic [thermal_overload_pin_timer_pkg::PRESCALE_W-1:0]           prescale;
    logic [7:0]                                        count;
    logic                                              seen;
    logic                                              exceeded;
    logic [7:0]                                        limit;
    logic [7:0]                                        ppr;
    logic [7:0]                                        rdata;
    thermal_overload_pin_timer_pkg::fan_pulses_s                      pulses;
  } state_s;

  state_s st_q;
  state_s st_d;

  function automatic logic [2:0] pulses_of(input logic [1:0] code);
    pulses_of = {1'b0, code} + 3'h1;
  endfunction : pulses_of

  logic       asserted;
  logic       tick;
  logic       rd_status;
  logic       rd_int2;
  logic [7:0] count_inc;
  logic [7:0] status_view;

  assign asserted  = !thermal_overload_pin_n_in;
  assign rd_status = reg_req_in.rd && (reg_req_in.addr == thermal_overload_pin_timer_pkg::DURATION_STATUS_ADDR);
  assign rd_int2   = reg_req_in.rd && (reg_req_in.addr == thermal_overload_pin_timer_pkg::INT_STATUS2_ADDR);
  // prescale wraps once per duration unit
  assign tick      = (st_q.state == thermal_overload_pin_timer_pkg::TIMER_TIMING) && asserted &&
                     (st_q.prescale == thermal_overload_pin_timer_pkg::PRESCALE_W'(TICK_CYCLES - 1));
  // saturate so a very long overload never wraps to a short reading
  assign count_inc = (st_q.count == thermal_overload_pin_timer_pkg::COUNT_MAX) ? st_q.count
                                                                : st_q.count + 8'h01;
  // below the first threshold only the seen flag shows
  assign status_view = (st_q.count < thermal_overload_pin_timer_pkg::FIRST_THRESHOLD) ?
                       {7'h00, st_q.seen} : {st_q.count[7:1], st_q.count[0] | st_q.seen};

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    if (clk_en_in) begin
      // reads: registered data, clear-on-read effects; hardware sets win below
      if (reg_req_in.rd) begin
        unique case (reg_req_in.addr)
          thermal_overload_pin_timer_pkg::INT_STATUS2_ADDR:
            st_d.rdata = 8'(st_q.exceeded) << thermal_overload_pin_timer_pkg::EXCEEDED_BIT;
          thermal_overload_pin_timer_pkg::DURATION_STATUS_ADDR: st_d.rdata = status_view;
          thermal_overload_pin_timer_pkg::DURATION_LIMIT_ADDR:  st_d.rdata = st_q.limit;
          thermal_overload_pin_timer_pkg::PULSES_PER_REV_ADDR:  st_d.rdata = st_q.ppr;
          default:                               st_d.rdata = 8'h00;
        endcase
      end
      if (rd_status) begin
        st_d.seen  = 1'b0;
        st_d.count = 8'h00;
      end
      if (rd_int2) begin
        st_d.exceeded = 1'b0;
      end
      if (reg_req_in.wr) begin
        if (reg_req_in.addr == thermal_overload_pin_timer_pkg::DURATION_LIMIT_ADDR) begin
          st_d.limit = reg_req_in.wdata;
        end
        if (reg_req_in.addr == thermal_overload_pin_timer_pkg::PULSES_PER_REV_ADDR) begin
          st_d.ppr = reg_req_in.wdata;
        end
      end
      unique case (st_q.state)
        thermal_overload_pin_timer_pkg::TIMER_IDLE: begin
          st_d.prescale = '0;
          if (asserted) begin
            st_d.state = thermal_overload_pin_timer_pkg::TIMER_TIMING;
            st_d.seen  = 1'b1;
            if (st_q.limit == 8'h00) begin
              st_d.exceeded = 1'b1;
            end
          end
        end
        thermal_overload_pin_timer_pkg::TIMER_TIMING: begin
          if (!asserted) begin
            st_d.state = thermal_overload_pin_timer_pkg::TIMER_IDLE;
          end else if (tick) begin
            st_d.prescale = '0;
            st_d.count    = rd_status ? 8'h01 : count_inc;
            if (count_inc > st_q.limit) begin
              st_d.exceeded = 1'b1;
            end
          end else begin
            st_d.prescale = st_q.prescale + 1'b1;
          end
        end
        default: st_d.state = thermal_overload_pin_timer_pkg::TIMER_IDLE;
      endcase
      // decode of each fan's two-bit field
      st_d.pulses.first  = pulses_of(st_q.ppr[thermal_overload_pin_timer_pkg::FIRST_FAN_LSB +: 2]);
      st_d.pulses.second = pulses_of(st_q.ppr[thermal_overload_pin_timer_pkg::SECOND_FAN_LSB +: 2]);
      st_d.pulses.third  = pulses_of(st_q.ppr[thermal_overload_pin_timer_pkg::THIRD_FAN_LSB +: 2]);
      st_d.pulses.fourth = pulses_of(st_q.ppr[thermal_overload_pin_timer_pkg::FOURTH_FAN_LSB +: 2]);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q          <= '0;
      st_q.state    <= thermal_overload_pin_timer_pkg::TIMER_IDLE;
      st_q.limit    <= thermal_overload_pin_timer_pkg::DURATION_LIMIT_RST;
      st_q.ppr      <= thermal_overload_pin_timer_pkg::PULSES_PER_REV_RST;
      st_q.pulses   <= '{3'h2, 3'h2, 3'h2, 3'h2};
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_out              = st_q.rdata;
  assign duration_exceeded_flag_out = st_q.exceeded;
  assign fan_pulses_out             = st_q.pulses;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_zero_limit_flag: assert property (
    clk_en_in && st_q.state == thermal_overload_pin_timer_pkg::TIMER_IDLE && asserted && st_q.limit == 8'h00
    |=> duration_exceeded_flag_out)
    else $error("zero limit did not flag on assertion");

  a_exceed_on_tick: assert property (
    clk_en_in && tick && count_inc > st_q.limit |=> duration_exceeded_flag_out)
    else $error("count beyond limit did not set flag");

  a_no_early_flag: assert property (
    clk_en_in && tick && count_inc <= st_q.limit && !st_q.exceeded && st_q.limit != 8'h00
    |=> !duration_exceeded_flag_out)
    else $error("flag set before count passed limit");

  a_count_step: assert property (
    clk_en_in && tick && !rd_status && st_q.count != thermal_overload_pin_timer_pkg::COUNT_MAX
    |=> st_q.count == $past(st_q.count) + 8'h01)
    else $error("duration count did not advance on tick");

  a_limit_write: assert property (
    clk_en_in && reg_req_in.wr && reg_req_in.addr == thermal_overload_pin_timer_pkg::DURATION_LIMIT_ADDR
    |=> st_q.limit == $past(reg_req_in.wdata))
    else $error("limit write lost");

  a_ppr_write_read: assert property (
    clk_en_in && reg_req_in.wr && reg_req_in.addr == thermal_overload_pin_timer_pkg::PULSES_PER_REV_ADDR
    ##1 clk_en_in && reg_req_in.rd && reg_req_in.addr == thermal_overload_pin_timer_pkg::PULSES_PER_REV_ADDR
    |=> reg_rdata_out == $past(reg_req_in.wdata, 2))
    else $error("pulses-per-rev readback wrong");

  a_first_fan_pulse_count_decode: assert property (
    clk_en_in |=> fan_pulses_out.first == 3'($past(st_q.ppr[1:0])) + 3'h1)
    else $error("fan one pulse count wrong");

  a_second_fan_pulse_count_decode: assert property (
    clk_en_in |=> fan_pulses_out.second == 3'($past(st_q.ppr[3:2])) + 3'h1)
    else $error("fan two pulse count wrong");

  a_third_fan_pulse_count_decode: assert property (
    clk_en_in |=> fan_pulses_out.third == 3'($past(st_q.ppr[5:4])) + 3'h1)
    else $error("fan three pulse count wrong");

  a_fourth_fan_pulse_count_decode: assert property (
    clk_en_in |=> fan_pulses_out.fourth == 3'($past(st_q.ppr[7:6])) + 3'h1)
    else $error("fan four pulse count wrong");

  a_int2_read: assert property (
    clk_en_in && rd_int2
    |=> (reg_rdata_out & 8'hDF) == 8'h00 && reg_rdata_out[5] == $past(st_q.exceeded))
    else $error("interrupt status read wrong");

  a_seen_clear: assert property (
    clk_en_in && rd_status && !asserted |=> !st_q.seen)
    else $error("seen flag not cleared by read");

  a_count_saturate: assert property (
    clk_en_in && tick && !rd_status && st_q.count == thermal_overload_pin_timer_pkg::COUNT_MAX
    |=> st_q.count == thermal_overload_pin_timer_pkg::COUNT_MAX)
    else $error("duration count wrapped");

  a_limit_readback: assert property (
    clk_en_in && reg_req_in.rd && reg_req_in.addr == thermal_overload_pin_timer_pkg::DURATION_LIMIT_ADDR
    |=> reg_rdata_out == $past(st_q.limit))
    else $error("limit readback wrong");

  a_upper_zero: assert property (
    clk_en_in && rd_status && st_q.count < thermal_overload_pin_timer_pkg::FIRST_THRESHOLD
    |=> reg_rdata_out[7:1] == 7'h00)
    else $error("upper duration bits not zero below threshold");

  a_seen_set: assert property (
    clk_en_in && st_q.state == thermal_overload_pin_timer_pkg::TIMER_IDLE && asserted
    |=> st_q.seen)
    else $error("seen flag not set on assertion");

endmodule : thermal_overload_pin_duration_limit

// ---- test/overload_source.sv ----
// far-side model that drives the active-low overload pin
module overload_source (
  // clock
  input  wire logic clk_in,
  // request from the bench, pin to the block
  input  wire logic overload_req_in,
  output logic      pin_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin_n_out = 1'h1;
  // changes just after the edge so the block always samples a settled level
  always @(posedge clk_in) pin_n_out <= #1 ~overload_req_in;
endmodule : overload_source

// ---- test/testbench.sv ----
// self-checking bench for the overload timer and pulses-per-rev registers
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                         clk, rst_n, ovl, pin_n, flag, en;
  logic [7:0]                   rdata, d;
  thermal_overload_pin_timer_pkg::reg_req_s    req;
  thermal_overload_pin_timer_pkg::fan_pulses_s fans;
  int                           fails, n_compared, cycles;
  logic [7:0]                   codes [4] = '{8'h1B, 8'hE4, 8'h00, 8'hFF};

  // short tick keeps the run brief, expectations use 4
  thermal_overload_pin_duration_limit #(.TICK_CYCLES(4)) thermal_overload_pin_duration_limit_inst (
    .clk_in(clk), .rst_n_in(rst_n), .clk_en_in(en), .reg_req_in(req),
    .reg_rdata_out(rdata), .thermal_overload_pin_n_in(pin_n),
    .duration_exceeded_flag_out(flag), .fan_pulses_out(fans));
  overload_source overload_source_inst (.clk_in(clk), .overload_req_in(ovl), .pin_n_out(pin_n));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  function automatic logic [11:0] fan_exp(input logic [7:0] v);
    return {3'(v[7:6]) + 3'h1, 3'(v[5:4]) + 3'h1, 3'(v[3:2]) + 3'h1, 3'(v[1:0]) + 3'h1};
  endfunction : fan_exp

  // idle cycle after each strobe so it is never reassigned in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: v};
    @(posedge clk);
    #1 req.wr = 1'h0;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    req.rd = 1'h1;
    req.addr = a;
    @(posedge clk);
    #1 req.rd = 1'h0;
    @(posedge clk);
    #1 d = rdata;
  endtask : rd

  task automatic wait_edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_edges

  ////////////////////////////////////////////////////////////////////////////////
  task automatic reset_and_map;
    rd(8'h7A);
    check(d, thermal_overload_pin_timer_pkg::DURATION_LIMIT_RST);
    rd(8'h7B);
    check(d, 8'h55);
    check(fans, fan_exp(8'h55));
    rd(8'h10);
    check(d, 8'h00);
    wr(8'h7A, 8'hA5);
    rd(8'h7A);
    check(d, 8'hA5);
    foreach (codes[i]) begin
      wr(8'h7B, codes[i]);
      check(fans, fan_exp(codes[i]));
      rd(8'h7B);
      check(d, codes[i]);
    end
  endtask : reset_and_map

  task automatic zero_limit;
    wr(8'h7A, 8'h00);
    ovl = 1'h1;
    wait_edges(3);
    check(flag, 1'h1);
    ovl = 1'h0;
    rd(8'h42);
    check(d, 8'h20);
    rd(8'h42);
    check(d, 8'h00);
    rd(8'h79);
  endtask : zero_limit

  task automatic one_unit;
    wr(8'h7A, 8'hFF);
    ovl = 1'h1;
    wait_edges(7);
    ovl = 1'h0;
    rd(8'h79);
    check(d, 8'h01);
    wr(8'h7A, 8'h01);
    ovl = 1'h1;
    wait_edges(9);
    check(flag, 1'h0);
    wait_edges(1);
    check(flag, 1'h1);
    ovl = 1'h0;
    rd(8'h79);
    check(d, 8'h03);
    rd(8'h79);
    check(d, 8'h00);
    rd(8'h42);
    check(d, 8'h20);
  endtask : one_unit

  // a write while the enable is low must not land
  task automatic frozen;
    en = 1'h0;
    wr(8'h7A, 8'h3C);
    en = 1'h1;
    rd(8'h7A);
    check(d, 8'h01);
  endtask : frozen

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    rst_n = 1'h0;
    req = '0;
    ovl = 1'h0;
    en = 1'h1;
    fails = 0;
    n_compared = 0;
    cycles = 0;
    wait_edges(8);
    rst_n = 1'h1;
    reset_and_map();
    zero_limit();
    one_unit();
    frozen();
    test_done();
  end
endmodule : testbench
